// *** design/cvt_pkg.sv ***
// constants, types and timing counts for the character video timing generator
//
// Behaviour
// - 4.5 us prescaler carry times timing pulse, hsync and blank start
// - one sweep spans 13 carries, 58.5 us
// - horizontal divider is 4-bit, reloads 7 on carry
// - timing pulse per sweep; hsync 4.5 us later
// - blanking starts at timing pulse, 10-20 us long
// - dot clock runs only while blanking is off
// - composite sync merges hsync and vsync, apart
// - sweep-in-row counter advances once per sweep
// - row reset every 15th sweep, low, delayed
// - row counter advances every 15 sweeps
// - row msb set in lower half of screen
// - 8 blanked sweeps below last displayed sweep
// - seven sync sweeps, then retrace allowance sweeps
// - symbol counter counts strobes; 64 adds bit
// - blanking holds symbol counter at zero
// - symbol and row counts form refresh address
// - dot-blank pulse once per sweep, setting dependent
// - dot counter reloads 6, strobe every tenth dot
// - strobe latches character and advances address
// - 277 sweeps per frame, 240 visible

package cvt_pkg;

   // =====================================================================
   // clock and horizontal time base
   // =====================================================================
   localparam int CLK_PERIOD_NS = 4;         // 250 MHz system clock
   localparam int TICK_NS       = 4500;      // prescaler carry period
   localparam logic [3:0] HDIV_LOAD = 4'h7;  // divider reload value
   localparam int HDIV_SPAN     = 16 - 7;    // counts per divider carry
   localparam int PRE_CYC       = TICK_NS / (CLK_PERIOD_NS * HDIV_SPAN);
   localparam logic [6:0] PRE_LAST = 7'(PRE_CYC - 1);
   localparam int SWEEP_TICKS   = 13;        // carries per sweep
   localparam logic [3:0] HPH_LAST = 4'(SWEEP_TICKS - 1);
   localparam logic [3:0] HPH_PRE  = 4'(SWEEP_TICKS - 2);
   localparam logic [3:0] HPH_SYNC = 4'h0;   // phase holding hsync

   // =====================================================================
   // horizontal blanking and dot generation
   // =====================================================================
   localparam int BLANK_MIN_NS  = 10000;
   localparam int BLANK_MAX_NS  = 20000;
   localparam logic [12:0] BLANK_MIN_CYC =
      13'((BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [12:0] BLANK_MAX_CYC = 13'(BLANK_MAX_NS / CLK_PERIOD_NS);
   localparam logic [12:0] BLANK_RST_CYC = 13'hea6;  // 15 us after reset
   localparam logic [3:0]  DOT_DIV_RST   = 4'h1;     // dot every 2 cycles
   localparam logic [3:0]  DOT_LOAD      = 4'h6;     // ten dots per symbol

   // =====================================================================
   // vertical counting
   // =====================================================================
   localparam logic [3:0] SROW_LAST  = 4'he;      // 15 sweeps per row
   localparam logic [8:0] VIS_SWEEPS = 9'h0f0;    // 240 visible sweeps
   localparam logic [8:0] FRAME_LAST = 9'h114;    // 277 sweeps per frame
   localparam logic [8:0] VSYNC_FIRST = 9'h0f8;   // after 8 bottom sweeps
   localparam logic [8:0] VSYNC_END   = 9'h0ff;   // seven sync sweeps
   localparam logic [4:0] SYM_LAST32  = 5'h1f;

   // =====================================================================
   // carriers
   // =====================================================================
   typedef struct packed {
      logic [12:0] blank_len;   // blanking length in clock cycles
      logic [3:0]  dot_div;     // dot period minus one, in cycles
   } cvt_cfg_t;

   typedef struct packed {
      logic tpulse;     // once-per-sweep timing pulse
      logic hsync;
      logic vsync;
      logic csync;
      logic hblank;
      logic vblank;
      logic dot_clk;    // one-cycle dot strobe
      logic eoc;        // end-of-character strobe
      logic dot_blank;
      logic row_rst_n;  // active-low row reset pulse
   } cvt_vid_t;

endpackage : cvt_pkg

// *** design/cvt_load_ctr.sv ***
// 4-bit loadable binary counter that reloads a preset on carry
`timescale 1ns/1ps
`default_nettype none

module cvt_load_ctr #(
   parameter logic [3:0] LOAD = 4'h0
) (
   input  wire logic       sys_clk_i,  // system clock
   input  wire logic       sys_rst_i,  // async reset, high
   input  wire logic       en_i,       // count enable
   output var  logic [3:0] cnt_o,      // present count
   output var  logic       co_o        // carry, count at all ones
);
   import cvt_pkg::*;

   logic [3:0] cnt_q;

   // =====================================================================
   // count with reload instead of wrapping through zero
   // =====================================================================
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= LOAD;
      end else if (en_i) begin
         if (cnt_q == 4'hf) begin
            cnt_q <= LOAD;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // carry is combinational so the parent sees it in the same cycle
   assign cnt_o = cnt_q;
   assign co_o  = (cnt_q == 4'hf);

endmodule : cvt_load_ctr
`default_nettype wire

// *** design/cvt_timing_gen.sv ***
// raster timing generator: horizontal, dot, symbol and vertical counting
`timescale 1ns/1ps
`default_nettype none

module cvt_timing_gen (
   input  wire logic              sys_clk_i,    // system clock, 250 MHz
   input  wire logic              sys_rst_i,    // async reset, high
   input  wire cvt_pkg::cvt_cfg_t cfg_i,        // blank length, dot rate
   input  wire logic              row64_i,      // 64-symbol jumper pin
   input  wire logic [7:0]        char_i,       // display memory data
   output var  cvt_pkg::cvt_vid_t vid_o,        // sync, blank, strobes
   output var  logic [9:0]        addr_o,       // refresh address
   output var  logic [7:0]        char_o,       // latched character
   output var  logic [3:0]        sweep_row_o,  // sweep within row
   output var  logic [3:0]        row_o         // character row
);
   import cvt_pkg::*;

   // =====================================================================
   // declarations
   // =====================================================================
   cvt_cfg_t    cfg_q;
   logic        r64_s1_q;
   logic        r64_s2_q;
   logic        r64_s3_q;
   logic        row64_q;
   logic [3:0]  hdiv_cnt;
   logic        hdiv_co;
   logic [6:0]  pre_q;
   logic        pre_tick;
   logic [3:0]  hph_q;
   logic        sweep_tick;
   logic        blank_start;
   logic [12:0] blank_cnt_q;
   logic        hblank;
   logic        hblank_prev_q;
   logic [3:0]  ddiv_q;
   logic        dot_tick;
   logic [3:0]  dot_cnt;
   logic        dot_co;
   logic        eoc;
   logic [5:0]  sym_q;
   logic [5:0]  sym_next;
   logic [3:0]  srow_q;
   logic [3:0]  row_q;
   logic [8:0]  line_q;
   logic        frame_wrap;
   logic        row_wrap;
   logic        row_wrap_q;
   logic        vblank;
   logic        vsync;
   logic        hsync;
   logic        dot_blank_q;
   cvt_vid_t    vid_q;
   logic [9:0]  addr_q;
   logic [7:0]  char_q;

   // =====================================================================
   // helper functions
   // =====================================================================
   // keep the blanking length inside the range the monitor tolerates
   function automatic logic [12:0] clamp_blank(input logic [12:0] v);
      logic [12:0] r;
      r = v;
      if (v < BLANK_MIN_CYC) begin
         r = BLANK_MIN_CYC;
      end else if (v > BLANK_MAX_CYC) begin
         r = BLANK_MAX_CYC;
      end
      return r;
   endfunction

   // row and symbol merged into one memory address
   function automatic logic [9:0] refresh_addr(input logic [3:0] row,
                                               input logic [5:0] sym,
                                               input logic       wide);
      logic [9:0] a;
      a = {1'b0, row, sym[4:0]};
      if (wide) begin
         a = {row, sym};
      end
      return a;
   endfunction

   // =====================================================================
   // settings held in the block
   // =====================================================================
   // sampled every cycle; dot rate acts from the next cycle, blank length from the next blank start
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_q.blank_len <= BLANK_RST_CYC;
         cfg_q.dot_div   <= DOT_DIV_RST;
      end else begin
         cfg_q.blank_len <= clamp_blank(cfg_i.blank_len);
         cfg_q.dot_div   <= cfg_i.dot_div;
      end
   end

   // jumper pin: three flops, accepted once the last two agree
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r64_s1_q <= 1'b0;
         r64_s2_q <= 1'b0;
         r64_s3_q <= 1'b0;
         row64_q  <= 1'b0;
      end else begin
         r64_s1_q <= row64_i;
         r64_s2_q <= r64_s1_q;
         r64_s3_q <= r64_s2_q;
         if (r64_s2_q == r64_s3_q) begin
            row64_q <= r64_s3_q;
         end
      end
   end

   // =====================================================================
   // horizontal time base
   // =====================================================================
   // first stage: divide by nine by reloading seven on carry
   cvt_load_ctr #(
      .LOAD (HDIV_LOAD)
   ) u_hdiv (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (1'b1),
      .cnt_o     (hdiv_cnt),
      .co_o      (hdiv_co)
   );

   // second stage brings the carry out to one every 4.5 us
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_q <= 7'h00;
      end else if (hdiv_co) begin
         if (pre_q == PRE_LAST) begin
            pre_q <= 7'h00;
         end else begin
            pre_q <= pre_q + 7'h01;
         end
      end
   end

   assign pre_tick = hdiv_co && (pre_q == PRE_LAST);

   // sweep phase: thirteen carries make one 58.5 us sweep
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hph_q <= 4'h0;
      end else if (pre_tick) begin
         if (hph_q == HPH_LAST) begin
            hph_q <= 4'h0;
         end else begin
            hph_q <= hph_q + 4'h1;
         end
      end
   end

   // sweep edge: last carry of a sweep, where hsync begins
   assign sweep_tick  = pre_tick && (hph_q == HPH_LAST);
   assign blank_start = pre_tick && (hph_q == HPH_PRE);
   assign hsync       = (hph_q == HPH_SYNC);

   // =====================================================================
   // horizontal blanking
   // =====================================================================
   // a down counter stands in for the stretching monostable
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         blank_cnt_q <= 13'h0000;
      end else if (blank_start) begin
         blank_cnt_q <= cfg_q.blank_len;
      end else if (blank_cnt_q != 13'h0000) begin
         blank_cnt_q <= blank_cnt_q - 13'h0001;
      end
   end

   assign hblank = (blank_cnt_q != 13'h0000);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hblank_prev_q <= 1'b0;
      end else begin
         hblank_prev_q <= hblank;
      end
   end

   // =====================================================================
   // dot generation
   // =====================================================================
   // rate divider is parked at zero while blanked, so the first dot
   // after blanking always lands in the first cycle with the blank off
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ddiv_q <= 4'h0;
      end else if (hblank) begin
         ddiv_q <= 4'h0;
      end else if (ddiv_q == cfg_q.dot_div) begin
         ddiv_q <= 4'h0;
      end else begin
         ddiv_q <= ddiv_q + 4'h1;
      end
   end

   assign dot_tick = !hblank && (ddiv_q == 4'h0);

   // dot counter: reload six, carry on every tenth dot
   cvt_load_ctr #(
      .LOAD (DOT_LOAD)
   ) u_dot (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (dot_tick),
      .cnt_o     (dot_cnt),
      .co_o      (dot_co)
   );

   assign eoc = dot_tick && dot_co;

   // =====================================================================
   // symbol counter
   // =====================================================================
   // in 32-symbol mode the top bit is held clear, so the count wraps
   // at 32 rather than spilling into the next row's addresses
   assign sym_next = sym_q + 6'h01;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sym_q <= 6'h00;
      end else if (hblank) begin
         sym_q <= 6'h00;
      end else if (eoc) begin
         sym_q <= {row64_q & sym_next[5], sym_next[4:0]};
      end
   end

   // =====================================================================
   // vertical counting
   // =====================================================================
   assign frame_wrap = sweep_tick && (line_q == FRAME_LAST);
   assign row_wrap   = sweep_tick && (srow_q == SROW_LAST);

   // sweep index within the frame
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         line_q <= 9'h000;
      end else if (frame_wrap) begin
         line_q <= 9'h000;
      end else if (sweep_tick) begin
         line_q <= line_q + 9'h001;
      end
   end

   // sweep within the character row, zeroed every 15th sweep
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         srow_q <= 4'h0;
      end else if (frame_wrap || row_wrap) begin
         srow_q <= 4'h0;
      end else if (sweep_tick) begin
         srow_q <= srow_q + 4'h1;
      end
   end

   // character row, stepped by each completed group of 15 sweeps
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         row_q <= 4'h0;
      end else if (frame_wrap) begin
         row_q <= 4'h0;
      end else if (row_wrap) begin
         row_q <= row_q + 4'h1;
      end
   end

   // remembers that this sweep began with a row reset
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         row_wrap_q <= 1'b0;
      end else if (sweep_tick) begin
         row_wrap_q <= row_wrap || frame_wrap;
      end
   end

   // bottom blanking and sync sweeps; the rest of the retrace blanked
   assign vblank = (line_q >= VIS_SWEEPS);
   assign vsync  = (line_q >= VSYNC_FIRST) && (line_q < VSYNC_END);

   // =====================================================================
   // dot-blank pulse
   // =====================================================================
   // opens as blanking ends and closes on the first strobe, so its
   // place follows the blank length and its width the dot rate;
   // opening wins a tie with a strobe so no sweep loses its pulse
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dot_blank_q <= 1'b0;
      end else if (hblank_prev_q && !hblank) begin
         dot_blank_q <= 1'b1;
      end else if (eoc) begin
         dot_blank_q <= 1'b0;
      end
   end

   // =====================================================================
   // video outputs
   // =====================================================================
   // all outputs are registered, so each lags its cause by one cycle
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         vid_q <= '0;
         vid_q.row_rst_n <= 1'b1;
      end else begin
         vid_q.tpulse    <= (hph_q == HPH_LAST);
         vid_q.hsync     <= hsync;
         vid_q.vsync     <= vsync;
         vid_q.csync     <= hsync ^ vsync;
         vid_q.hblank    <= hblank;
         vid_q.vblank    <= vblank;
         vid_q.dot_clk   <= dot_tick;
         vid_q.eoc       <= eoc;
         vid_q.dot_blank <= dot_blank_q;
         vid_q.row_rst_n <= !(row_wrap_q && (hph_q == HPH_SYNC));
      end
   end

   // refresh address follows the counters one cycle later
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_q <= 10'h000;
      end else begin
         addr_q <= refresh_addr(row_q, sym_q, row64_q);
      end
   end

   // character latch: holds the current symbol until the next strobe
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         char_q <= 8'h00;
      end else if (eoc) begin
         char_q <= char_i;
      end
   end

   assign vid_o       = vid_q;
   assign addr_o      = addr_q;
   assign char_o      = char_q;
   assign sweep_row_o = srow_q;
   assign row_o       = row_q;

endmodule : cvt_timing_gen
`default_nettype wire

// *** sim/cvt_timing_gen_assertions.sv ***
// port checker for the raster timing generator
`timescale 1ns/1ps
`default_nettype none

// =============================================
// checker
module cvt_chk (
   input wire logic              sys_clk_i,   // clock
   input wire logic              sys_rst_i,   // reset
   input wire cvt_pkg::cvt_cfg_t cfg_i,       // settings
   input wire logic              row64_i,     // width pin
   input wire logic [7:0]        char_i,      // memory data
   input wire cvt_pkg::cvt_vid_t vid_o,       // timing
   input wire logic [9:0]        addr_o,      // address
   input wire logic [7:0]        char_o,      // latch
   input wire logic [3:0]        sweep_row_o, // sweep count
   input wire logic [3:0]        row_o        // row count
);
   import cvt_pkg::*;
   localparam int TICK = PRE_CYC * HDIV_SPAN;
   logic [12:0] hs_q;
   logic [12:0] hb_q;
   logic [12:0] hb_exp_q;
   logic [12:0] lim_d;
   logic [3:0]  dots_q;
   logic        seen_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   // clamped length, latched while idle: a blank keeps the value from its start
   assign lim_d = (cfg_i.blank_len < BLANK_MIN_CYC) ? BLANK_MIN_CYC :
                  (cfg_i.blank_len > BLANK_MAX_CYC) ? BLANK_MAX_CYC : cfg_i.blank_len;

   // run lengths of sync and blank, dots since the last end of character
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hs_q     <= 13'h0;
         hb_q     <= 13'h0;
         hb_exp_q <= 13'h0;
         dots_q   <= 4'h0;
         seen_q   <= 1'b0;
      end else begin
         hs_q   <= vid_o.hsync ? hs_q + 13'h1 : 13'h0;
         hb_q   <= vid_o.hblank ? hb_q + 13'h1 : 13'h0;
         dots_q <= vid_o.eoc ? 4'h0 : dots_q + {3'h0, vid_o.dot_clk};
         if (!vid_o.hblank) hb_exp_q <= lim_d;
         if (vid_o.eoc) seen_q <= 1'b1;
      end
   end

   csync_merge_a: assert property (vid_o.csync == (vid_o.hsync ^ vid_o.vsync))
      else $error("composite sync wrong");
   dot_gate_a: assert property (vid_o.dot_clk |-> !vid_o.hblank)
      else $error("dot during blank");
   hsync_width_a: assert property ($fell(vid_o.hsync) |-> hs_q == 13'(TICK))
      else $error("hsync width wrong");
   hsync_follow_a: assert property ($fell(vid_o.tpulse) |-> $rose(vid_o.hsync))
      else $error("hsync not after timing pulse");
   blank_start_a: assert property ($rose(vid_o.tpulse) |-> $rose(vid_o.hblank))
      else $error("blank not at timing pulse");
   blank_len_a: assert property ($fell(vid_o.hblank) |-> hb_q == hb_exp_q)
      else $error("blank length wrong");
   dot_ten_a: assert property (vid_o.eoc && seen_q |-> dots_q + {3'h0, vid_o.dot_clk} == 4'ha)
      else $error("character not ten dots");
   sym_hold_a: assert property (vid_o.hblank && $past(vid_o.hblank) |-> addr_o[4:0] == 5'h0)
      else $error("symbol count not held");
   char_hold_a: assert property (!$stable(char_o) |-> vid_o.eoc)
      else $error("latch moved without strobe");
   latch_load_a: assert property (vid_o.eoc |-> char_o == $past(char_i))
      else $error("latch missed memory data");
   row_step_a: assert property (!$stable(sweep_row_o) |->
      sweep_row_o == $past(sweep_row_o) + 4'h1 || sweep_row_o == 4'h0)
      else $error("sweep count jumped");

   cover property ($fell(vid_o.hblank));
   cover property (vid_o.eoc && addr_o[5]);
   cover property ($rose(vid_o.hsync) && vid_o.csync);
endmodule // cvt_chk

bind cvt_timing_gen cvt_chk u_chk (
   .sys_clk_i, .sys_rst_i, .cfg_i, .row64_i, .char_i,
   .vid_o, .addr_o, .char_o, .sweep_row_o, .row_o
);

`default_nettype wire

// *** sim/cvt_crt_model.sv ***
// refresh memory and monitor model facing the timing generator
`timescale 1ns/1ps
`default_nettype none

// =============================================
// monitor and memory
module cvt_crt_model (
   input  wire logic              sys_clk_i,   // clock
   input  wire logic              sys_rst_i,   // reset
   input  wire cvt_pkg::cvt_vid_t vid_i,       // sync and blank
   input  wire logic [9:0]        addr_i,      // refresh address
   output var  logic [7:0]        data_o,      // memory data
   output var  logic [15:0]       sweep_len_o  // line period seen
);
   import cvt_pkg::*;
   logic [7:0]  mem_q [1024];
   logic [15:0] cnt_q;
   logic        hs_q;

   // fixed pattern so that each latched character differs
   initial begin
      for (int i = 0; i < 'h400; i++) begin
         mem_q[i] = 8'(i * 'h25 + 'hb);
      end
   end
   assign data_o = mem_q[addr_i];

   // the set locks to rising composite sync only, as a real receiver does
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q       <= 16'h0;
         hs_q        <= 1'b0;
         sweep_len_o <= 16'h0;
      end else begin
         hs_q  <= vid_i.csync;
         cnt_q <= (vid_i.csync && !hs_q) ? 16'h1 : cnt_q + 16'h1;
         if (vid_i.csync && !hs_q) sweep_len_o <= cnt_q;
      end
   end
endmodule // cvt_crt_model

`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the raster timing generator
`timescale 1ns/1ps
`default_nettype none

// =============================================
// bench top
module tb;
   import cvt_pkg::*;
   localparam int TICK  = PRE_CYC * HDIV_SPAN;  // cycles per carry
   localparam int SWEEP = TICK * SWEEP_TICKS;   // cycles per sweep
   logic        sys_clk_i;
   logic        sys_rst_i;
   logic        row64_i;
   logic [7:0]  char_i;
   logic [7:0]  char_o;
   logic [9:0]  addr_o;
   logic [3:0]  sweep_row_o;
   logic [3:0]  row_o;
   logic [15:0] sweep_len;
   logic [15:0] lfsr_q;
   logic [3:0]  psr;
   logic        psr_ok;
   cvt_cfg_t    cfg_i;
   cvt_cfg_t    cur;
   cvt_vid_t    vid_o;
   cvt_vid_t    prev;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;

   cvt_timing_gen u_dut (
      .sys_clk_i, .sys_rst_i, .cfg_i, .row64_i, .char_i,
      .vid_o, .addr_o, .char_o, .sweep_row_o, .row_o
   );
   cvt_crt_model u_crt (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .vid_i       (vid_o),
      .addr_i      (addr_o),
      .data_o      (char_i),
      .sweep_len_o (sweep_len)
   );

   // =============================================
   // helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [12:0] exp_blank(input logic [12:0] b);
      return (b < BLANK_MIN_CYC) ? BLANK_MIN_CYC : (b > BLANK_MAX_CYC) ? BLANK_MAX_CYC : b;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // inputs change 1 ns after the edge, outputs are read there too
   task automatic step();
      prev = vid_o;
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (3) step();
      check("reset outputs", {22'h0, vid_o}, 32'h1);
      check("reset counts", {6'h0, char_o, addr_o, sweep_row_o, row_o}, 32'h0);
      sys_rst_i = 1'b0;
      repeat (3) step();
      check("restart sync", vid_o.hsync, 32'h1);
      psr_ok = 1'b0;
      $display("reset test done");
   endtask

   // one sweep from blank start; settings for the next blank go in early on
   task automatic run_sweep(input cvt_cfg_t nxt, input logic wide);
      int         hs_at = -1;
      int         tp = 0;
      int         hb = 0;
      int         dbr = 0;
      int         last = -1;
      int         k = 0;
      logic [1:0] bad = 2'h0;
      logic       hi5 = 1'b0;
      logic [3:0] sr = 4'h0;
      while (!(vid_o.tpulse && !prev.tpulse) && k < 'h3e80) begin
         step();
         k++;
      end
      for (int n = 0; n < SWEEP; n++) begin
         if (n == 'ha) begin
            cfg_i   = nxt;
            row64_i = wide;
         end
         if (n == 'h1b58) sr = sweep_row_o;
         if (hs_at < 0 && vid_o.hsync) hs_at = n;
         tp  += int'(vid_o.tpulse);
         hb  += int'(vid_o.hblank);
         dbr += int'(vid_o.dot_blank && !prev.dot_blank);
         hi5 |= addr_o[5];
         if (vid_o.hblank) last = -1;
         else if (vid_o.dot_clk) begin
            if (last >= 0 && n - last != nxt.dot_div + 1) bad[0] = 1'b1;
            last = n;
         end
         if (vid_o.csync !== vid_o.hsync || vid_o.vblank !== 1'b0 || row_o !== 4'h0
             || vid_o.row_rst_n !== 1'b1 || (vid_o.dot_blank && vid_o.hblank)) bad[1] = 1'b1;
         step();
      end
      check("sweep period", {prev.tpulse, vid_o.tpulse}, 32'h1);
      check("timing pulse width", tp, TICK);
      check("hsync delay", hs_at, TICK);
      check("blank length", hb, exp_blank(cur.blank_len));
      check("dot period", bad[0], 32'h0);
      check("sync and vertical", bad[1], 32'h0);
      check("dot blank pulses", dbr, 32'h1);
      check("symbol width bit", wide ? hi5 : !hi5, 32'h1);
      check("monitor period", sweep_len, SWEEP);
      if (psr_ok) check("sweep in row", sr, (psr == 4'he) ? 4'h0 : psr + 4'h1);
      psr    = sr;
      psr_ok = 1'b1;
      cur    = nxt;
      $display("sweep test done blank %0d dots %0d wide %0b", hb, nxt.dot_div, wide);
   endtask

   // =============================================
   // clock, watchdog, sequence
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // a hang counts as a mismatch and ends the run
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 'h17318) begin
         error_cnt++;
         $display("Error timeout after %0d cycles", cyc);
         print_verdict();
      end
   end

   initial begin
      sys_rst_i = 1'b1;
      row64_i   = 1'b0;
      prev      = '0;
      cfg_i     = '{blank_len: BLANK_MAX_CYC, dot_div: 4'h1};
      cur       = cfg_i;
      lfsr_q    = 16'hfbd9;
      do_reset();
      lfsr_q = lfsr_next(lfsr_q);
      // random legal length, fastest dots, wide rows
      run_sweep('{blank_len: BLANK_MIN_CYC + 13'(lfsr_q % 16'h9c5), dot_div: 4'h0}, 1'b1);
      // too short, so clamped up; slowest dots
      run_sweep('{blank_len: 13'h3e8, dot_div: 4'hf}, 1'b0);
      lfsr_q = lfsr_next(lfsr_q);
      // too long, so clamped down after a reset in mid-run
      run_sweep('{blank_len: 13'h1b58, dot_div: lfsr_q[3:0]}, lfsr_q[4]);
      do_reset();
      lfsr_q = lfsr_next(lfsr_q);
      run_sweep('{blank_len: BLANK_MIN_CYC, dot_div: lfsr_q[7:4]}, 1'b1);
      print_verdict();
   end
endmodule // tb

`default_nettype wire
